// >>> verilog/afe_sleep_consts.svh
`ifndef AFE_SLEEP_CONSTS_SVH
`define AFE_SLEEP_CONSTS_SVH

// ----------------------------------------
// timing figures and clock rate
// ----------------------------------------
`define CLOCK_MHZ            125
`define ENTRY_MAX_US         1
`define CONV_WAKE_US         1
`define CHAIN_WAKE_MIN_US    2
`define CHAIN_WAKE_PERCENT   1
// entry deadline, rounded down
`define ENTRY_MAX_CYC        (`ENTRY_MAX_US * `CLOCK_MHZ)
// wake times, rounded up
`define CONV_WAKE_CYC        (`CONV_WAKE_US * `CLOCK_MHZ)
`define CHAIN_WAKE_MIN_CYC   (`CHAIN_WAKE_MIN_US * `CLOCK_MHZ)
`define CHAIN_WAKE_DIV       (100 / `CHAIN_WAKE_PERCENT)
`define CHANNELS             8
`define SYNC_DELAY_CYC       2

`endif

// >>> verilog/afe_sleep_pkg.sv
package afe_sleep_pkg;
   typedef enum logic [1:0] {
      MODE_AWAKE,
      MODE_PARTIAL,
      MODE_COMPLETE
   } sleep_mode_e;
endpackage

// >>> verilog/afe_power_down_control.sv
`timescale 1ns/1ps
`include "afe_sleep_consts.svh"

// Function
// - final sleep is OR of applicable controls
// - higher priority control overrides lower ones
// - global pin sleeps everything, highest priority
// - chain pin sleeps preamp, attenuator, amplifier
// - chain fast-sleep bit sleeps whole gain chain
// - converter full-sleep bit sleeps converter
// - converter fast-sleep bit sleeps converter
// - separate bit sleeps attenuator and amplifier
// - separate bit sleeps preamp only
// - partial sleep keeps references powered
// - partial sleep keeps frame, bit clocks
// - partial sleep via chain or converter pins or fast bits
// - complete sleep via full bits or global
// - complete sleep switches off references too
// - entry takes effect under one microsecond
// - converter ready one microsecond after wake
// - chain ready after max(2us, 1% down)
// - per-channel eight-bit sleep masks
module afe_power_down_control
   import afe_sleep_pkg::*;
#(
   parameter int CHANNELS = `CHANNELS,
   parameter int DOWN_W   = 32
) (
   input  wire logic                clock,
   input  wire logic                resetn,
   input  wire logic                globalSleepPin,
   input  wire logic                gainChainSleepPin,
   input  wire logic                converterSleepPin,
   input  wire logic                gainChainFastSleep,
   input  wire logic                gainChainFullSleep,
   input  wire logic                converterFastSleep,
   input  wire logic                converterFullSleep,
   input  wire logic                attenuatorAmpSleep,
   input  wire logic                preampSleep,
   input  wire logic [CHANNELS-1:0] converterChannelSleepMask,
   input  wire logic [CHANNELS-1:0] gainChainChannelSleepMask,
   output logic      [CHANNELS-1:0] preampOff,
   output logic      [CHANNELS-1:0] attenuatorOff,
   output logic      [CHANNELS-1:0] gainAmpOff,
   output logic      [CHANNELS-1:0] converterOff,
   output logic                     referenceOff,
   output logic                     serialClocksOff,
   output logic      [1:0]          sleepMode,
   output logic                     converterReady,
   output logic                     gainChainReady
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;

   // pins are asynchronous; two stages guard against metastability, but a glitch caught at a rising edge still reaches the outputs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pinMeta_reg <= 3'h0;
         pinSync_reg <= 3'h0;
      end else begin
         pinMeta_reg <= {globalSleepPin, gainChainSleepPin,
                         converterSleepPin};
         pinSync_reg <= pinMeta_reg;
      end
   end

   logic globalS;
   logic chainPinS;
   logic convPinS;
   assign globalS   = pinSync_reg[2];
   assign chainPinS = pinSync_reg[1];
   assign convPinS  = pinSync_reg[0];

   // ----------------------------------------
   // priority combine
   // ----------------------------------------
   // all levels only ever add sleep, so the OR realises the override
   logic chainHigh;
   logic convHigh;
   logic chainAny;
   logic convAny;
   logic completeReq;
   logic partialReq;
   logic [CHANNELS-1:0] preampNext;
   logic [CHANNELS-1:0] attenNext;
   logic [CHANNELS-1:0] convNext;

   assign chainHigh   = globalS | chainPinS | gainChainFullSleep;
   assign convHigh    = globalS | convPinS | converterFullSleep;
   assign chainAny    = chainHigh | gainChainFastSleep;
   assign convAny     = convHigh | converterFastSleep;
   assign completeReq = globalS | gainChainFullSleep
                      | converterFullSleep;
   assign partialReq  = chainPinS | convPinS | gainChainFastSleep
                      | converterFastSleep;

   assign preampNext = {CHANNELS{chainAny | preampSleep}}
                     | gainChainChannelSleepMask;
   assign attenNext  = {CHANNELS{chainAny | attenuatorAmpSleep}}
                     | gainChainChannelSleepMask;
   assign convNext   = {CHANNELS{convAny}}
                     | converterChannelSleepMask;

   // ----------------------------------------
   // sleep outputs
   // ----------------------------------------
   sleep_mode_e modeNext;
   always_comb begin
      if (completeReq)
         modeNext = MODE_COMPLETE;
      else if (partialReq)
         modeNext = MODE_PARTIAL;
      else
         modeNext = MODE_AWAKE;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         preampOff       <= '0;
         attenuatorOff   <= '0;
         gainAmpOff      <= '0;
         converterOff    <= '0;
         referenceOff    <= 1'b0;
         serialClocksOff <= 1'b0;
         sleepMode       <= MODE_AWAKE;
      end else begin
         preampOff       <= preampNext;
         attenuatorOff   <= attenNext;
         gainAmpOff      <= attenNext;
         converterOff    <= convNext;
         // partial sleep leaves references and serial clocks alive
         referenceOff    <= completeReq;
         serialClocksOff <= completeReq;
         sleepMode       <= modeNext;
      end
   end

   // ----------------------------------------
   // wake timers
   // ----------------------------------------
   localparam int CONV_WAKE  = `CONV_WAKE_CYC;
   localparam int CHAIN_MIN  = `CHAIN_WAKE_MIN_CYC;
   localparam int CHAIN_DIV  = `CHAIN_WAKE_DIV;

   logic              convSleepPrev_reg;
   logic [15:0]       convWait_reg;
   logic              chainSleepPrev_reg;
   logic [DOWN_W-1:0] downTime_reg;
   logic [DOWN_W-1:0] chainWait_reg;
   logic [DOWN_W-1:0] chainWaitNext;

   // percentage of down time; saturating counter caps very long sleeps
   always_comb begin
      chainWaitNext = downTime_reg / DOWN_W'(CHAIN_DIV);
      if (chainWaitNext < DOWN_W'(CHAIN_MIN))
         chainWaitNext = DOWN_W'(CHAIN_MIN);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         convSleepPrev_reg <= 1'b0;
         convWait_reg      <= 16'h0000;
         converterReady    <= 1'b1;
      end else begin
         convSleepPrev_reg <= convAny;
         if (convAny) begin
            convWait_reg   <= 16'h0000;
            converterReady <= 1'b0;
         end else if (convSleepPrev_reg) begin
            convWait_reg   <= 16'(CONV_WAKE - 1);
         end else if (convWait_reg != 16'h0000) begin
            convWait_reg   <= convWait_reg - 16'h0001;
         end else begin
            converterReady <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chainSleepPrev_reg <= 1'b0;
         downTime_reg       <= '0;
         chainWait_reg      <= '0;
         gainChainReady     <= 1'b1;
      end else begin
         chainSleepPrev_reg <= chainAny;
         if (chainAny) begin
            gainChainReady <= 1'b0;
            chainWait_reg  <= '0;
            if (!chainSleepPrev_reg)
               downTime_reg <= DOWN_W'(1);
            else if (downTime_reg != '1)
               downTime_reg <= downTime_reg + DOWN_W'(1);
         end else if (chainSleepPrev_reg) begin
            chainWait_reg  <= chainWaitNext - DOWN_W'(1);
         end else if (chainWait_reg != '0) begin
            chainWait_reg  <= chainWait_reg - DOWN_W'(1);
         end else begin
            gainChainReady <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // check helpers
   // ----------------------------------------
   // quiet time since each sleep request dropped, for the wake checks
   logic [15:0]       convQuiet_reg;
   logic [DOWN_W-1:0] chainQuiet_reg;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         convQuiet_reg <= 16'h0000;
      end else if (convAny) begin
         convQuiet_reg <= 16'h0000;
      end else if (convQuiet_reg != 16'hFFFF) begin
         convQuiet_reg <= convQuiet_reg + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chainQuiet_reg <= '0;
      end else if (chainAny) begin
         chainQuiet_reg <= '0;
      end else if (chainQuiet_reg != '1) begin
         chainQuiet_reg <= chainQuiet_reg + DOWN_W'(1);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_global_all;
      @(posedge clock) disable iff (!resetn)
      (pinSync_reg[2]) |=> (&preampOff && &converterOff && referenceOff);
   endproperty
   a_global_all: assert property (p_global_all)
      else $error("global pin did not sleep all blocks");

   property p_chain_pin;
      @(posedge clock) disable iff (!resetn)
      (pinSync_reg[1]) |=> (&preampOff && &attenuatorOff && &gainAmpOff);
   endproperty
   a_chain_pin: assert property (p_chain_pin)
      else $error("chain pin did not sleep gain chain");

   property p_fast_chain;
      @(posedge clock) disable iff (!resetn)
      gainChainFastSleep |=> (&gainAmpOff && &preampOff);
   endproperty
   a_fast_chain: assert property (p_fast_chain)
      else $error("chain fast bit ignored");

   property p_conv_bits;
      @(posedge clock) disable iff (!resetn)
      (converterFullSleep || converterFastSleep) |=> &converterOff;
   endproperty
   a_conv_bits: assert property (p_conv_bits)
      else $error("converter sleep bit ignored");

   property p_preamp_only;
      @(posedge clock) disable iff (!resetn)
      (preampSleep && !attenuatorAmpSleep && !chainAny
       && gainChainChannelSleepMask == '0)
         |=> (&preampOff && attenuatorOff == '0);
   endproperty
   a_preamp_only: assert property (p_preamp_only)
      else $error("preamp bit leaked to other blocks");

   property p_attn_only;
      @(posedge clock) disable iff (!resetn)
      (attenuatorAmpSleep && !preampSleep && !chainAny
       && gainChainChannelSleepMask == '0)
         |=> (&attenuatorOff && &gainAmpOff && preampOff == '0);
   endproperty
   a_attn_only: assert property (p_attn_only)
      else $error("attenuator bit leaked to preamp");

   property p_partial_refs;
      @(posedge clock) disable iff (!resetn)
      (partialReq && !completeReq) |=> (!referenceOff && !serialClocksOff);
   endproperty
   a_partial_refs: assert property (p_partial_refs)
      else $error("partial sleep stopped references");

   property p_complete_off;
      @(posedge clock) disable iff (!resetn)
      completeReq |=> (referenceOff && serialClocksOff
                       && sleepMode == MODE_COMPLETE);
   endproperty
   a_complete_off: assert property (p_complete_off)
      else $error("complete sleep left circuits on");

   property p_mode_partial;
      @(posedge clock) disable iff (!resetn)
      (partialReq && !completeReq) |=> sleepMode == MODE_PARTIAL;
   endproperty
   a_mode_partial: assert property (p_mode_partial)
      else $error("partial sleep mode not reported");

   property p_entry_time;
      @(posedge clock) disable iff (!resetn)
      $rose(globalSleepPin) |-> ##[1:4] referenceOff;
   endproperty
   a_entry_time: assert property (p_entry_time)
      else $error("sleep entry too slow");

   // a new request restarts the wake, so the window counts quiet cycles
   property p_conv_early;
      @(posedge clock) disable iff (!resetn)
      $rose(converterReady) |-> (convQuiet_reg >= 16'(CONV_WAKE)
                                 && convQuiet_reg <= 16'(CONV_WAKE + 4));
   endproperty
   a_conv_early: assert property (p_conv_early)
      else $error("converter ready outside wake window");

   property p_conv_late;
      @(posedge clock) disable iff (!resetn)
      (convQuiet_reg == 16'(CONV_WAKE + 4)) |-> converterReady;
   endproperty
   a_conv_late: assert property (p_conv_late)
      else $error("converter ready too late");

   property p_chain_early;
      @(posedge clock) disable iff (!resetn)
      $rose(gainChainReady) |-> chainQuiet_reg >= DOWN_W'(CHAIN_MIN);
   endproperty
   a_chain_early: assert property (p_chain_early)
      else $error("gain chain ready before minimum wake");

   property p_chain_min;
      @(posedge clock) disable iff (!resetn)
      $fell(chainAny) |-> ##[245:255] !gainChainReady;
   endproperty
   a_chain_min: assert property (p_chain_min)
      else $error("gain chain ready too early");

   property p_mask;
      @(posedge clock) disable iff (!resetn)
      (converterChannelSleepMask != '0)
         |=> ((converterOff & $past(converterChannelSleepMask))
              == $past(converterChannelSleepMask));
   endproperty
   a_mask: assert property (p_mask)
      else $error("channel mask not applied");

   property p_conv_unmasked;
      @(posedge clock) disable iff (!resetn)
      !convAny |=> (converterOff == $past(converterChannelSleepMask));
   endproperty
   a_conv_unmasked: assert property (p_conv_unmasked)
      else $error("converter slept without a request");

endmodule

// >>> verif/sys_controller_model.sv
`timescale 1ns/1ps

module sys_controller_model (
   input  wire logic       clock,
   output logic            globalSleepPin,
   output logic            gainChainSleepPin,
   output logic            converterSleepPin,
   output logic            gainChainFastSleep,
   output logic            gainChainFullSleep,
   output logic            converterFastSleep,
   output logic            converterFullSleep,
   output logic            attenuatorAmpSleep,
   output logic            preampSleep,
   output logic [7:0]      converterChannelSleepMask,
   output logic [7:0]      gainChainChannelSleepMask
);
   // ----------------------------------------
   // control drive, just after a rising edge
   // ----------------------------------------
   task automatic apply(input logic [24:0] c);
      @(posedge clock);
      #1;
      globalSleepPin = c[24];
      gainChainSleepPin = c[23];
      converterSleepPin = c[22];
      gainChainFastSleep = c[21];
      gainChainFullSleep = c[20];
      converterFastSleep = c[19];
      converterFullSleep = c[18];
      attenuatorAmpSleep = c[17];
      preampSleep = c[16];
      converterChannelSleepMask = c[15:8];
      gainChainChannelSleepMask = c[7:0];
   endtask

   // short pin pulse kept clear of any rising edge, so no flop may catch it
   task automatic glitch();
      @(posedge clock);
      #2;
      globalSleepPin = 1'b1;
      #3;
      globalSleepPin = 1'b0;
   endtask

   initial begin
      globalSleepPin = 1'b0;
      gainChainSleepPin = 1'b0;
      converterSleepPin = 1'b0;
      gainChainFastSleep = 1'b0;
      gainChainFullSleep = 1'b0;
      converterFastSleep = 1'b0;
      converterFullSleep = 1'b0;
      attenuatorAmpSleep = 1'b0;
      preampSleep = 1'b0;
      converterChannelSleepMask = 8'h00;
      gainChainChannelSleepMask = 8'h00;
   end
endmodule

// >>> verif/afe_power_down_control_tb_top.sv
`timescale 1ns/1ps
`include "afe_sleep_consts.svh"

module afe_power_down_control_tb_top;
   logic        clock, resetn;
   logic        globalSleepPin, gainChainSleepPin, converterSleepPin;
   logic        gainChainFastSleep, gainChainFullSleep;
   logic        converterFastSleep, converterFullSleep;
   logic        attenuatorAmpSleep, preampSleep;
   logic [7:0]  converterChannelSleepMask, gainChainChannelSleepMask;
   logic [7:0]  preampOff, attenuatorOff, gainAmpOff, converterOff;
   logic        referenceOff, serialClocksOff, converterReady, gainChainReady;
   logic [1:0]  sleepMode;
   int          badCount, compares;
   // {mode, pins[2:0], bits[5:0], converter mask, chain mask}; mode 3 = skip
   logic [26:0] cases [13] = '{27'h0000000, 27'h5000000, 27'h2800000,
      27'h2400000, 27'h2200000, 27'h2080000, 27'h4040000, 27'h4100000,
      27'h6020000, 27'h6010000, 27'h600A53C, 27'h4248142, 27'h6420000};

   sys_controller_model ctl (.clock(clock), .globalSleepPin(globalSleepPin),
      .gainChainSleepPin(gainChainSleepPin),
      .converterSleepPin(converterSleepPin),
      .gainChainFastSleep(gainChainFastSleep),
      .gainChainFullSleep(gainChainFullSleep),
      .converterFastSleep(converterFastSleep),
      .converterFullSleep(converterFullSleep),
      .attenuatorAmpSleep(attenuatorAmpSleep), .preampSleep(preampSleep),
      .converterChannelSleepMask(converterChannelSleepMask),
      .gainChainChannelSleepMask(gainChainChannelSleepMask));

   afe_power_down_control uut (.clock(clock), .resetn(resetn),
      .globalSleepPin(globalSleepPin), .gainChainSleepPin(gainChainSleepPin),
      .converterSleepPin(converterSleepPin),
      .gainChainFastSleep(gainChainFastSleep),
      .gainChainFullSleep(gainChainFullSleep),
      .converterFastSleep(converterFastSleep),
      .converterFullSleep(converterFullSleep),
      .attenuatorAmpSleep(attenuatorAmpSleep), .preampSleep(preampSleep),
      .converterChannelSleepMask(converterChannelSleepMask),
      .gainChainChannelSleepMask(gainChainChannelSleepMask),
      .preampOff(preampOff), .attenuatorOff(attenuatorOff),
      .gainAmpOff(gainAmpOff), .converterOff(converterOff),
      .referenceOff(referenceOff), .serialClocksOff(serialClocksOff),
      .sleepMode(sleepMode), .converterReady(converterReady),
      .gainChainReady(gainChainReady));

   // ----------------------------------------
   // clock, free running through every sleep
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic checkRange(input int n, input int lo, input int hi);
      compares++;
      if (n < lo || n > hi) begin
         badCount++;
         $display("wrong value at %0t got %h exp %h", $time, n, lo);
      end
   endtask

   task automatic summarize();
      $display("compares %0d, mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // counts edges from release until the chosen ready flag rises
   task automatic waitReady(input bit chain, input int lo, input int hi);
      int n;
      n = 0;
      while (n < 2000 && (chain ? gainChainReady : converterReady) !== 1'b1)
      begin
         @(posedge clock);
         #2;
         n++;
      end
      if (n >= 2000) begin
         badCount++;
         summarize();
      end
      checkRange(n, lo, hi);
   endtask

   initial begin
      logic [26:0] e;
      logic        ch;
      badCount = 0;
      compares = 0;
      resetn = 1'b0;
      repeat (6) @(posedge clock);
      #1 resetn = 1'b1;
      #1 check({preampOff, attenuatorOff, gainAmpOff, converterOff}, 32'h0);
      check({26'h0, referenceOff, serialClocksOff, sleepMode,
             converterReady, gainChainReady}, 32'h3);
      $display("test reset done");
      foreach (cases[i]) begin
         e = cases[i];
         ch = e[24] | e[23] | e[21] | e[20];
         ctl.apply(e[24:0]);
         repeat (4) @(posedge clock);
         #2;
         check({preampOff, attenuatorOff, gainAmpOff, converterOff},
            {{8{ch | e[16]}} | e[7:0], {2{{8{ch | e[17]}} | e[7:0]}},
             {8{e[24] | e[22] | e[19] | e[18]}} | e[15:8]});
         check({30'h0, referenceOff, serialClocksOff},
               {30'h0, {2{e[24] | e[20] | e[18]}}});
         if (e[26:25] != 2'h3)
            check({30'h0, sleepMode}, {30'h0, e[26:25]});
      end
      $display("test priority done");
      ctl.apply(25'h0080000);
      repeat (2) @(posedge clock);
      #2 check({31'h0, converterReady}, 32'h0);
      ctl.apply(25'h0);
      waitReady(1'b0, `CONV_WAKE_CYC, `CONV_WAKE_CYC + 4);
      $display("test converter wake done");
      ctl.apply(25'h0200000);
      repeat (20) @(posedge clock);
      #2 check({31'h0, gainChainReady}, 32'h0);
      ctl.apply(25'h0);
      waitReady(1'b1, `CHAIN_WAKE_MIN_CYC, `CHAIN_WAKE_MIN_CYC + 4);
      ctl.apply(25'h0200000);
      repeat (40000) @(posedge clock);
      ctl.apply(25'h0);
      waitReady(1'b1, 40000 / `CHAIN_WAKE_DIV,
                40000 / `CHAIN_WAKE_DIV + 6);
      $display("test chain wake done");
      ctl.apply(25'h1000000);
      repeat (4) @(posedge clock);
      #1 resetn = 1'b0;
      #1 check({preampOff, attenuatorOff, gainAmpOff, converterOff}, 32'h0);
      check({26'h0, referenceOff, serialClocksOff, sleepMode,
             converterReady, gainChainReady}, 32'h3);
      @(posedge clock);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clock);
      #2 check({31'h0, referenceOff}, 32'h1);
      ctl.apply(25'h0);
      repeat (4) @(posedge clock);
      $display("test mid reset done");
      ctl.glitch();
      repeat (5) begin
         @(posedge clock);
         #2 check({31'h0, referenceOff}, 32'h0);
      end
      $display("test pin glitch done");
      summarize();
   end
endmodule
